// ---- logic/asr_pkg.sv ----
// Constants, field layouts and types for the analog select and reset block
package asr_pkg;

  // Clock and timing
  localparam int CLK_HZ = 200_000_000;
  localparam int RS_MIN_MS = 12;
  localparam int PU_HOLD_S = 4;
  // Least time in whole cycles; the division truncates
  localparam int RS_MIN_CYC = (CLK_HZ / 1000 * RS_MIN_MS + 0);
  localparam int PU_HOLD_CYC = CLK_HZ * PU_HOLD_S;
  // Cycles for the pin synchronisers to fill after reset release
  localparam logic [31:0] PU_SETTLE_CYC = 32'h0000_0004;

  // Intelligent input slots and function codes (decimal 16 and 18)
  localparam int NUM_SLOTS_MAX = 8;
  localparam logic [7:0] FUNC_AT = 8'h10;
  localparam logic [7:0] FUNC_RS = 8'h12;

  // Setting encodings
  localparam logic [1:0] FSRC_ANALOG = 2'h1;
  localparam logic [1:0] ASO_CURRENT = 2'h0;
  localparam logic [1:0] ASO_AUX = 2'h1;
  localparam logic [1:0] BIP_UNIPOLAR = 2'h0;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_SLOT_LO = 5'h04;
  localparam logic [4:0] OFS_SLOT_HI = 5'h08;
  localparam logic [4:0] OFS_NC = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

  // Reset values: slot 0 carries reset, slot 1 carries source select
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [31:0] SLOT_LO_RST = 32'h0000_1012;
  localparam logic [31:0] SLOT_HI_RST = 32'h0000_0000;
  localparam logic [7:0] NC_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_RESET_OP = 0;
  localparam int IRQ_TRIP_CLR = 1;
  localparam int IRQ_COMM_ERR = 2;

  typedef enum logic [1:0] {SRC_MAIN_V, SRC_CURRENT, SRC_AUX_V} asr_src_t;

  // Control register layout, bit 0 upward: fsrc, aso, bipolar, trail_edge
  typedef struct packed {
    logic trail_edge;
    logic [1:0] bipolar;
    logic [1:0] aso;
    logic [1:0] fsrc;
  } asr_cfg_t;

  // Analog routing towards the converter
  typedef struct packed {
    asr_src_t src;
    logic src_valid;
    logic bipolar_ok;
    logic dir_from_cmd;
  } asr_ana_t;

  // Live status register layout, top bit first down to bit 0
  typedef struct packed {
    logic comm_err;
    logic alarm;
    logic trip;
    logic motor_en;
    logic rs_on;
    logic at_on;
    asr_ana_t ana;
  } asr_stat_t;

  typedef enum logic [1:0] {PU_SETTLE, PU_WATCH, PU_DONE} asr_pu_t;

endpackage : asr_pkg

// ---- logic/asr_sync.sv ----
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module asr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end

endmodule : asr_sync

// ---- logic/asr_top.sv ----
// Analog source select and reset terminal logic with Avalon-MM registers
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// R1: Select active with option 00 routes current input, 4 to 20 mA.
// R2: Select active with option 01 routes the auxiliary voltage input.
// R3: Select inactive routes the main voltage input whatever the option.
// R4: Only voltage sources may be bipolar; current direction comes from run commands.
// R5: Configuring party sets frequency source to analog before selection matters.
// R6: Code 16 is source select, code 18 reset, on any of eight slots.
// R7: A reset pulse runs the reset operation, cancelling any trip.
// R8: While reset is on: motor off, trip cleared, power-up reset applied.
// R9: Driving party holds reset pulses at least 12 ms.
// R10: Alarm output drops within 30 ms of the reset onset.
// R11: Edge setting picks leading or trailing edge to trigger reset.
// R12: A reset slot is always normally open; closed setting is ignored.
// R13: Power-on runs the same reset operation as a terminal pulse.
// R14: Reset held over 4 s at power-up flags a comm error, cleared by key.
// R15: Driving party checks run command is off before issuing reset.
// R16: Terminals are synchronised; durations counted in clock cycles.
module asr_top
  import asr_pkg::*;
#(
  parameter int NUM_SLOTS = NUM_SLOTS_MAX,
  parameter int unsigned RS_MIN_CYCLES = RS_MIN_CYC,
  parameter int unsigned PU_HOLD_CYCLES = PU_HOLD_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Terminal pins
  input wire logic [NUM_SLOTS-1:0] term_in,
  input wire logic fwd_run_in,
  input wire logic rev_run_in,
  input wire logic op_key_in,
  // Trip source, same clock
  input wire logic trip_event,
  // Drive outputs
  output asr_ana_t ana_out,
  output logic motor_out_en,
  output logic run_reverse,
  output logic alarm_out,
  output logic powerup_reset,
  output logic reset_op_pulse,
  output logic comm_err,
  output logic irq
);

  // Refuse slot counts the slot registers cannot hold
  if (NUM_SLOTS < 1 || NUM_SLOTS > NUM_SLOTS_MAX)
  begin : g_bad_slots
    $error("asr_top: NUM_SLOTS must be 1 to 8");
  end
  if (RS_MIN_CYCLES < 2 || PU_HOLD_CYCLES < 2)
  begin : g_bad_counts
    $error("asr_top: cycle counts must be at least 2");
  end

  localparam logic [31:0] RS_MIN_W = RS_MIN_CYCLES;
  localparam logic [31:0] PU_HOLD_W = PU_HOLD_CYCLES;

  // Registers
  asr_cfg_t cfg_reg;
  logic [31:0] slot_lo_reg;
  logic [31:0] slot_hi_reg;
  logic [7:0] nc_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic ack_reg;

  // Synchronised pins
  logic [NUM_SLOTS-1:0] term_sync;
  logic fwd_sync;
  logic rev_sync;
  logic key_sync;
  logic key_prev_reg;

  // Reset terminal tracking
  logic [31:0] rs_cnt_reg;
  logic rs_prev_reg;
  logic rs_long_reg;
  logic trip_reg;
  logic trip_next;
  logic comm_err_next;
  asr_pu_t pu_state_reg;
  logic [31:0] pu_cnt_reg;
  asr_ana_t ana_next;
  asr_stat_t stat;

  // Pin synchronisers in one instance
  asr_sync #(
    .WIDTH(NUM_SLOTS + 3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_in({op_key_in, rev_run_in, fwd_run_in, term_in}),
    .sync_out({key_sync, rev_sync, fwd_sync, term_sync})
  ); // [R16]

  // Per-slot function decode
  wire [63:0] slot_all = {slot_hi_reg, slot_lo_reg};
  wire [NUM_SLOTS-1:0] is_rs;
  wire [NUM_SLOTS-1:0] is_at;
  for (genvar i = 0; i < NUM_SLOTS; i++)
  begin : g_slot
    assign is_rs[i] = slot_all[i*8 +: 8] == FUNC_RS; // [R6]
    assign is_at[i] = slot_all[i*8 +: 8] == FUNC_AT; // [R6]
  end

  // Reset slots ignore the normally closed setting
  wire rs_on = |(term_sync & is_rs); // [R12]
  wire at_on = |((term_sync ^ nc_reg[NUM_SLOTS-1:0]) & is_at);

  // Analog source selection
  wire sel_cur = at_on && cfg_reg.aso == ASO_CURRENT; // [R1]
  wire sel_aux = at_on && cfg_reg.aso == ASO_AUX; // [R2]
  wire [1:0] src_w = sel_cur ? SRC_CURRENT :
                     (sel_aux ? SRC_AUX_V : SRC_MAIN_V); // [R3]
  wire bip_ok = !sel_cur && cfg_reg.bipolar != BIP_UNIPOLAR; // [R4]
  assign ana_next.src = asr_src_t'(src_w);
  assign ana_next.src_valid = cfg_reg.fsrc == FSRC_ANALOG; // [R5]
  assign ana_next.bipolar_ok = bip_ok;
  assign ana_next.dir_from_cmd = !bip_ok; // [R4]

  // Reset pulse qualification, edges and power-up events
  wire rs_qual = rs_on && rs_cnt_reg == RS_MIN_W - 32'h1; // [R16]
  wire rs_trail = rs_prev_reg && !rs_on && rs_long_reg;
  wire rs_edge = cfg_reg.trail_edge ? rs_trail : rs_qual; // [R11]
  wire pu_fire = pu_state_reg == PU_SETTLE &&
                 pu_cnt_reg == PU_SETTLE_CYC - 32'h1; // [R13]
  wire pu_busy = pu_state_reg == PU_SETTLE;
  wire key_rise = key_sync && !key_prev_reg;
  wire pu_hold_hit = pu_state_reg == PU_WATCH && rs_on &&
                     pu_cnt_reg == PU_HOLD_W - 32'h1; // [R14]

  // Trip: a new trip wins over a clear in the same cycle
  wire trip_clr = rs_long_reg || rs_qual || rs_edge || pu_fire; // [R7] [R8]
  assign trip_next = trip_event || (trip_reg && !trip_clr);
  assign comm_err_next = pu_hold_hit ||
                         (comm_err && !(key_rise && !rs_on)); // [R14]

  // Interrupt status, sticky with write-one-to-clear; set wins
  wire bus_fire = (avs_read || avs_write) && ack_reg;
  wire wr_fire = bus_fire && avs_write;
  wire [IRQ_W-1:0] irq_evt = {pu_hold_hit, trip_reg && !trip_next,
                              rs_edge || pu_fire};
  wire [IRQ_W-1:0] irq_w1c = (wr_fire && avs_address == OFS_IRQ_STAT) ?
                             avs_writedata[IRQ_W-1:0] : '0;
  assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_evt;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Live status view
  assign stat.comm_err = comm_err;
  assign stat.alarm = alarm_out;
  assign stat.trip = trip_reg;
  assign stat.motor_en = motor_out_en;
  assign stat.rs_on = rs_on;
  assign stat.at_on = at_on;
  assign stat.ana = ana_out;

  // Read decode; unmapped offsets read zero
  wire [31:0] rd_mux =
    (avs_address == OFS_CTRL) ? {25'h0, cfg_reg} :
    (avs_address == OFS_SLOT_LO) ? slot_lo_reg :
    (avs_address == OFS_SLOT_HI) ? slot_hi_reg :
    (avs_address == OFS_NC) ? {24'h0, nc_reg} :
    (avs_address == OFS_STATUS) ? {{(32 - $bits(asr_stat_t)){1'b0}}, stat} :
    (avs_address == OFS_IRQ_STAT) ? {29'h0, irq_stat_reg} :
    (avs_address == OFS_IRQ_MASK) ? {29'h0, irq_mask_reg} : 32'h0000_0000;

  // Every access waits exactly one cycle, keeping read mux off the bus path
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  // Bus handshake and read data
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      if (avs_read && !ack_reg)
        avs_readdata <= rd_mux;
    end
  end

  // Software-written configuration
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_reg <= CTRL_RST;
      slot_lo_reg <= SLOT_LO_RST;
      slot_hi_reg <= SLOT_HI_RST;
      nc_reg <= NC_RST;
      irq_mask_reg <= IRQ_RST;
    end
    else if (wr_fire)
    begin
      if (avs_address == OFS_CTRL)
        cfg_reg <= avs_writedata[6:0];
      if (avs_address == OFS_SLOT_LO)
        slot_lo_reg <= avs_writedata;
      if (avs_address == OFS_SLOT_HI)
        slot_hi_reg <= avs_writedata;
      if (avs_address == OFS_NC)
        nc_reg <= avs_writedata[7:0];
      if (avs_address == OFS_IRQ_MASK)
        irq_mask_reg <= avs_writedata[IRQ_W-1:0];
    end
  end

  // Reset terminal on-time counter, saturating at the minimum width
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rs_cnt_reg <= 32'h0000_0000;
      rs_prev_reg <= 1'b0;
      rs_long_reg <= 1'b0;
    end
    else
    begin
      rs_prev_reg <= rs_on;
      if (!rs_on)
        rs_cnt_reg <= 32'h0000_0000;
      else if (rs_cnt_reg < RS_MIN_W)
        rs_cnt_reg <= rs_cnt_reg + 32'h1; // [R16]
      rs_long_reg <= rs_on && (rs_long_reg || rs_qual);
    end
  end

  // Power-up sequence: settle, fire reset, watch for a held terminal
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pu_state_reg <= PU_SETTLE;
      pu_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      unique case (pu_state_reg)
        PU_SETTLE:
        begin
          pu_cnt_reg <= pu_fire ? 32'h0000_0000 : pu_cnt_reg + 32'h1;
          if (pu_fire)
            pu_state_reg <= PU_WATCH; // [R13]
        end
        PU_WATCH:
        begin
          pu_cnt_reg <= pu_cnt_reg + 32'h1;
          if (!rs_on || pu_hold_hit)
            pu_state_reg <= PU_DONE; // [R14]
        end
        PU_DONE:
          pu_cnt_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Trip, alarm, comm error and interrupt state
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trip_reg <= 1'b0;
      alarm_out <= 1'b0;
      comm_err <= 1'b0;
      key_prev_reg <= 1'b0;
      irq_stat_reg <= IRQ_RST;
    end
    else
    begin
      trip_reg <= trip_next;
      alarm_out <= trip_next; // [R10]
      comm_err <= comm_err_next;
      key_prev_reg <= key_sync;
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Drive outputs; motor drops on the raw terminal, not the qualified one,
  // so a short reset glitch still stops the output safely
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      motor_out_en <= 1'b0;
      run_reverse <= 1'b0;
      powerup_reset <= 1'b1;
      reset_op_pulse <= 1'b0;
      ana_out <= '0;
    end
    else
    begin
      motor_out_en <= (fwd_sync ^ rev_sync) && !trip_next && !rs_on &&
                      !pu_busy; // [R8]
      run_reverse <= rev_sync && !fwd_sync; // [R4]
      powerup_reset <= rs_on || pu_busy; // [R8]
      reset_op_pulse <= rs_edge || pu_fire; // [R7] [R11] [R13]
      ana_out <= ana_next;
    end
  end

endmodule : asr_top

// ---- tb/asr_term_model.sv ----
// Model of the contacts and controller driving the terminals
`timescale 1ns/1ps
module asr_term_model (
  // Clock
  input wire logic sys_clk,
  // Contacts and commands
  output logic [7:0] term_in,
  output logic fwd_run_in,
  output logic rev_run_in,
  output logic op_key_in
);
  // Slot 0 closed from power-on for the held-reset case
  initial
  begin
    term_in = 8'h01;
    fwd_run_in = 1'b0;
    rev_run_in = 1'b0;
    op_key_in = 1'b0;
  end

  // Level change on one contact
  task automatic set_term(input int idx, input logic val);
    @(posedge sys_clk);
    term_in[idx] <= val;
  endtask : set_term

  // Contact pulse; run commands dropped on the same edge the contact closes, to avoid a restart
  task automatic pulse(input int idx, input int n);
    @(posedge sys_clk);
    fwd_run_in <= 1'b0;
    rev_run_in <= 1'b0;
    term_in[idx] <= 1'b1;
    repeat (n) @(posedge sys_clk);
    term_in[idx] <= 1'b0; // Real resets held the minimum width
  endtask : pulse

  // Operator key press
  task automatic key();
    @(posedge sys_clk);
    op_key_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    op_key_in <= 1'b0;
  endtask : key

  // Run command levels
  task automatic run(input logic fwd, input logic rev);
    @(posedge sys_clk);
    fwd_run_in <= fwd;
    rev_run_in <= rev;
  endtask : run
endmodule : asr_term_model

// ---- tb/asr_top_props.sv ----
// Port-level checks for the analog select and reset block
`timescale 1ns/1ps
module asr_top_props
  import asr_pkg::*;
#(
  parameter int NUM_SLOTS = 8,
  parameter int unsigned RS_MIN_CYCLES = 20,
  parameter int unsigned PU_HOLD_CYCLES = 50
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Terminals
  input wire logic [NUM_SLOTS-1:0] term_in,
  input wire logic fwd_run_in,
  input wire logic rev_run_in,
  input wire logic op_key_in,
  input wire logic trip_event,
  // Drive outputs
  input wire asr_ana_t ana_out,
  input wire logic motor_out_en,
  input wire logic run_reverse,
  input wire logic alarm_out,
  input wire logic powerup_reset,
  input wire logic reset_op_pulse,
  input wire logic comm_err,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Cycles in reset with alarm still up; bounds the clearing time
  logic [31:0] alarm_cnt_reg;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      alarm_cnt_reg <= 32'h0;
    else if (powerup_reset && alarm_out)
      alarm_cnt_reg <= alarm_cnt_reg + 32'h1;
    else
      alarm_cnt_reg <= 32'h0;
  end

  // Bus answers after exactly one wait cycle
  a_wait_one_cycle: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("wait not one cycle");
  // Current input never bipolar, direction from commands
  a_current_unipolar: assert property (ana_out.src == SRC_CURRENT |->
    !ana_out.bipolar_ok) else $error("current source bipolar");
  a_current_dir_cmd: assert property (ana_out.src == SRC_CURRENT &&
    ana_out.src_valid |-> ana_out.dir_from_cmd) else $error("current dir");
  // Reset operation flag is a single pulse
  a_op_pulse_one: assert property (reset_op_pulse |=>
    !reset_op_pulse) else $error("op pulse too long");
  // Motor off while reset applied
  a_motor_off_rst: assert property (powerup_reset |->
    !motor_out_en) else $error("motor on in reset");
  // Alarm drops in bounded time after reset onset
  a_alarm_clear_time: assert property (
    alarm_cnt_reg <= RS_MIN_CYCLES + 4) else $error("alarm kept");
  // Trip only from a trip event
  a_trip_source: assert property ($rose(alarm_out) |->
    $past(trip_event) || $past(trip_event, 2)) else $error("bad trip");
  // Trip stays until a reset clears it
  a_alarm_stays: assert property (alarm_out && !powerup_reset |=>
    alarm_out) else $error("trip lost");
  // Held reset indication is no fault
  a_comm_no_fault: assert property ($rose(comm_err) |->
    !alarm_out && powerup_reset) else $error("comm err fault");
endmodule : asr_top_props

bind asr_top asr_top_props #(.NUM_SLOTS(NUM_SLOTS),
  .RS_MIN_CYCLES(RS_MIN_CYCLES), .PU_HOLD_CYCLES(PU_HOLD_CYCLES))
  asr_top_props_i (.sys_clk(sys_clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .term_in(term_in),
  .fwd_run_in(fwd_run_in), .rev_run_in(rev_run_in),
  .op_key_in(op_key_in), .trip_event(trip_event), .ana_out(ana_out),
  .motor_out_en(motor_out_en), .run_reverse(run_reverse),
  .alarm_out(alarm_out), .powerup_reset(powerup_reset),
  .reset_op_pulse(reset_op_pulse), .comm_err(comm_err), .irq(irq));

// ---- tb/tb_top.sv ----
// Self-checking bench for the analog select and reset block
`timescale 1ns/1ps
module tb_top
  import asr_pkg::*;
;
  // Short counts keep the run brief
  localparam int unsigned RS_MIN = 20;
  localparam int unsigned PU_HOLD = 50;
  logic sys_clk, rst_b, avs_read, avs_write, trip_event, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic motor_out_en, run_reverse, alarm_out, powerup_reset;
  logic reset_op_pulse, comm_err, irq, fwd_run_in, rev_run_in, op_key_in;
  logic [7:0] term_in;
  asr_ana_t ana_out;
  asr_src_t es;
  int fail_count, comparisons, ops, o;

  asr_top #(.RS_MIN_CYCLES(RS_MIN), .PU_HOLD_CYCLES(PU_HOLD)) asr_top_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .term_in(term_in),
    .fwd_run_in(fwd_run_in), .rev_run_in(rev_run_in),
    .op_key_in(op_key_in), .trip_event(trip_event), .ana_out(ana_out),
    .motor_out_en(motor_out_en), .run_reverse(run_reverse),
    .alarm_out(alarm_out), .powerup_reset(powerup_reset),
    .reset_op_pulse(reset_op_pulse), .comm_err(comm_err), .irq(irq));
  asr_term_model asr_term_model_i (.sys_clk(sys_clk), .term_in(term_in),
    .fwd_run_in(fwd_run_in), .rev_run_in(rev_run_in),
    .op_key_in(op_key_in));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Reset operations seen
  always @(posedge sys_clk)
    if (reset_op_pulse === 1'b1)
      ops <= ops + 1;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Wait n edges, then settle to the falling edge for sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc

  // One Avalon transfer, held until waitrequest is low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    // Sample waitrequest at the rising edge itself, then release there
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      fail_count++;
      end_of_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rchk(input string nm, input logic [4:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk

  task automatic trip();
    @(posedge sys_clk);
    trip_event <= 1'b1;
    @(posedge sys_clk);
    trip_event <= 1'b0;
    cyc(4);
    chk("alarm set", 32'h1, 32'(alarm_out));
  endtask : trip

  initial
  begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    trip_event = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc(8);
    chk("power-on op", 32'h1, 32'(ops));
    cyc(PU_HOLD + 12);
    chk("comm_err", 32'h1, 32'(comm_err));
    asr_term_model_i.set_term(0, 1'b0);
    cyc(10);
    chk("comm_err kept", 32'h1, 32'(comm_err));
    asr_term_model_i.key();
    cyc(6);
    chk("comm_err clr", 32'h0, 32'(comm_err));
    $display("test power-on done");
    rchk("ctrl", OFS_CTRL, {25'h0, CTRL_RST});
    rchk("slot_lo", OFS_SLOT_LO, SLOT_LO_RST);
    rchk("slot_hi", OFS_SLOT_HI, SLOT_HI_RST);
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
    rchk("unmapped", 5'h1C, 32'h0);
    $display("test registers done");
    // Select on and off against both option values
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, OFS_CTRL, 32'h11 | (32'(i & 1) << 2));
      asr_term_model_i.set_term(1, i[1]);
      cyc(6);
      es = !i[1] ? SRC_MAIN_V : i[0] ? SRC_AUX_V : SRC_CURRENT;
      chk("src", 32'(es), 32'(ana_out.src));
      chk("bip", 32'(es != SRC_CURRENT), 32'(ana_out.bipolar_ok));
      chk("dir", 32'(es == SRC_CURRENT), 32'(ana_out.dir_from_cmd));
      chk("valid", 32'h1, 32'(ana_out.src_valid));
    end
    bus(1'b1, OFS_CTRL, 32'h10);
    cyc(4);
    chk("src off", 32'h0, 32'(ana_out.src_valid));
    $display("test analog select done");
    bus(1'b1, OFS_IRQ_STAT, 32'h7);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    bus(1'b1, OFS_NC, 32'h1);
    trip();
    o = ops;
    asr_term_model_i.pulse(0, RS_MIN / 2);
    cyc(5);
    chk("short pulse", 32'h1, 32'(alarm_out));
    asr_term_model_i.set_term(0, 1'b1);
    cyc(RS_MIN + 6);
    chk("motor off", 32'h0, 32'(motor_out_en));
    chk("pu reset", 32'h1, 32'(powerup_reset));
    chk("alarm clr", 32'h0, 32'(alarm_out));
    chk("lead op", 32'(o + 1), 32'(ops));
    chk("irq masked", 32'h0, 32'(irq));
    asr_term_model_i.set_term(0, 1'b0);
    cyc(5);
    rchk("irq stat", OFS_IRQ_STAT, 32'h3);
    bus(1'b1, OFS_IRQ_MASK, 32'h7);
    cyc(1);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b1, OFS_IRQ_STAT, 32'h3);
    rchk("irq w1c", OFS_IRQ_STAT, 32'h0);
    chk("irq low", 32'h0, 32'(irq));
    $display("test reset leading done");
    // Reset moved to slot 4, select to slot 0, trailing edge
    bus(1'b1, OFS_SLOT_LO, 32'h10);
    bus(1'b1, OFS_SLOT_HI, 32'h12);
    bus(1'b1, OFS_CTRL, 32'h55);
    bus(1'b1, OFS_NC, 32'h0);
    trip();
    o = ops;
    asr_term_model_i.set_term(4, 1'b1);
    cyc(RS_MIN + 6);
    chk("trail held", 32'(o), 32'(ops));
    chk("alarm slot4", 32'h0, 32'(alarm_out));
    asr_term_model_i.set_term(4, 1'b0);
    cyc(6);
    chk("trail op", 32'(o + 1), 32'(ops));
    asr_term_model_i.set_term(0, 1'b1);
    cyc(6);
    chk("src slot0", 32'(SRC_AUX_V), 32'(ana_out.src));
    chk("slot0 no rst", 32'h0, 32'(powerup_reset));
    $display("test remap trailing done");
    // Run commands: exactly one must be on for the motor to run
    asr_term_model_i.run(1'b1, 1'b0);
    cyc(4);
    chk("motor fwd", 32'h1, 32'(motor_out_en));
    chk("fwd dir", 32'h0, 32'(run_reverse));
    asr_term_model_i.run(1'b1, 1'b1);
    cyc(4);
    chk("motor both", 32'h0, 32'(motor_out_en));
    chk("both dir", 32'h0, 32'(run_reverse));
    asr_term_model_i.run(1'b0, 1'b1);
    cyc(4);
    chk("motor rev", 32'h1, 32'(motor_out_en));
    chk("rev dir", 32'h1, 32'(run_reverse));
    trip();
    chk("motor trip", 32'h0, 32'(motor_out_en));
    asr_term_model_i.pulse(4, RS_MIN + 4);
    cyc(6);
    chk("motor stop", 32'h0, 32'(motor_out_en));
    chk("alarm run clr", 32'h0, 32'(alarm_out));
    $display("test run commands done");
    end_of_test();
  end
endmodule : tb_top
